/* File: rtl/gpt_edge_detect.sv */
`timescale 1ns/1ps
module gpt_edge_detect (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Pin
  input wire logic i_pin,
  // Edges
  output logic o_level_sync,
  output logic o_rise_sync,
  output logic o_fall_sync,
  output logic o_rise_raw
);

  logic meta_q;
  logic sync_q;
  logic sync_dly_q;
  logic raw_q;
  logic raw_dly_q;

  // Two-flop path for the synchronised modes
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      sync_dly_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      sync_dly_q <= sync_q;
    end
  end

  // Single sample path: the pin is taken as clock synchronous
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      raw_q <= 1'b0;
      raw_dly_q <= 1'b0;
    end else begin
      raw_q <= i_pin;
      raw_dly_q <= raw_q;
    end
  end

  assign o_level_sync = sync_q;
  assign o_rise_sync = sync_q & ~sync_dly_q;
  assign o_fall_sync = ~sync_q & sync_dly_q;
  assign o_rise_raw = raw_q & ~raw_dly_q;

endmodule // gpt_edge_detect

/* File: rtl/gpt_pkg.sv */
package gpt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_COUNT = 10'h100;
  localparam logic [9:0] IDX_PERIOD = 10'h102;
  localparam logic [9:0] IDX_CONTROL = 10'h104;
  localparam logic [9:0] IDX_STATUS = 10'h106;
  localparam logic [9:0] IDX_MASK = 10'h107;
  localparam logic [9:0] IDX_OSC = 10'h108;

  // control_word fields
  localparam int unsigned CTL_ON = 15;
  localparam int unsigned CTL_IDLE_STOP = 13;
  localparam int unsigned CTL_GATE = 6;
  localparam int unsigned CTL_PS_HI = 5;
  localparam int unsigned CTL_PS_LO = 4;
  localparam int unsigned CTL_SYNC = 2;
  localparam int unsigned CTL_CS = 1;
  localparam logic [15:0] CONTROL_MASK = 16'hA076;

  // osc_control_word fields
  localparam int unsigned OSC_LP_EN = 1;
  localparam logic [15:0] OSC_MASK = 16'h0002;

  // Status and mask layout
  localparam int unsigned ST_W = 3;
  localparam int unsigned ST_MATCH = 0;
  localparam int unsigned ST_GATE = 1;
  localparam int unsigned ST_WAKE = 2;

  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] OSC_RESET = 16'h0000;
  localparam logic [ST_W-1:0] STATUS_RESET = 3'h0;

  // Prescaler terminal counts for divide by 1, 8, 64, 256
  localparam logic [7:0] PS_LAST_1 = 8'h00;
  localparam logic [7:0] PS_LAST_8 = 8'h07;
  localparam logic [7:0] PS_LAST_64 = 8'h3F;
  localparam logic [7:0] PS_LAST_256 = 8'hFF;

  function automatic logic [7:0] prescale_last(input logic [1:0] sel);
    case (sel)
      2'h0: prescale_last = PS_LAST_1;
      2'h1: prescale_last = PS_LAST_8;
      2'h2: prescale_last = PS_LAST_64;
      default: prescale_last = PS_LAST_256;
    endcase
  endfunction

endpackage

/* File: rtl/gpt_prescaler.sv */
`timescale 1ns/1ps
module gpt_prescaler
  import gpt_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Control
  input wire logic i_enable,
  input wire logic i_clear,
  input wire logic [1:0] i_select,
  // Ticks
  input wire logic i_tick,
  output logic o_tick
);

  logic [7:0] div_q;
  logic at_last;

  assign at_last = (div_q == prescale_last(i_select));
  assign o_tick = i_enable & i_tick & at_last;

  // Halted while disabled, so a clear then has no effect
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      div_q <= PS_LAST_1;
    end else if (i_enable) begin
      if (i_clear) begin
        div_q <= PS_LAST_1;
      end else if (i_tick) begin
        div_q <= at_last ? PS_LAST_1 : div_q + 8'h01;
      end
    end
  end

  // A halted prescaler keeps its phase
  halt_hold_a: assert property (
    @(posedge i_clock) disable iff (!i_rst_b) !i_enable |=> $stable(div_q)
  ) else $error("prescaler moved while disabled");

endmodule // gpt_prescaler

/* File: rtl/gpt_timer.sv */
// Behaviour
// - Internal mode counts cycles, wraps after period.
// - Idle freezes count when idle_stop set.
// - Sync counter counts synchronised external rising edges.
// - Async counter counts raw edges, idle stop.
// - Gated mode counts cycles while gate high.
// - Gate falling edge sets timer interrupt flag.
// - Prescaler divides by 1, 8, 64, 256.
// - Prescaler cleared on count write, disable, reset.
// - Disabled prescaler is halted, cannot clear.
// - Control write leaves the count unchanged.
// - Sleep counting only enabled, external, async.
// - Period match sets sticky flag, software clears.
// - clock_source_select picks internal or external clock.
// - RTC mode counts low-power oscillator edges.
// - lp_osc_enable blocks normal modes, wakes on carry.
// - RTC runs through sleep with oscillator active (here only with external_sync_select clear).
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module gpt_timer
  import gpt_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Avalon-MM slave, byte addressed
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // External inputs
  input wire logic i_gate_clock_pin,
  input wire logic i_lp_osc_clock,
  // CPU power state
  input wire logic i_cpu_idle,
  input wire logic i_cpu_sleep,
  // Events
  output logic o_irq,
  output logic o_wake_event
);

  function automatic logic [15:0] merge16(
    input logic [15:0] old_v,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    merge16 = old_v;
    if (be[0]) begin
      merge16[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wdata[15:8];
    end
  endfunction

  logic [15:0] count_value_q;
  logic [15:0] period_value_q;
  logic [15:0] control_word_q;
  logic [15:0] osc_control_word_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic ack_q;
  logic [31:0] readdata_q;
  logic wake_q;

  // Bus decode
  logic [9:0] bus_index;
  logic access_fire;
  logic wr_fire;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_status;
  logic wr_mask;
  logic wr_osc;
  logic [15:0] control_next;

  assign bus_index = i_avs_address[11:2];
  assign access_fire = (i_avs_read | i_avs_write) & ack_q;
  assign wr_fire = i_avs_write & ack_q;
  assign wr_count = wr_fire & (bus_index == IDX_COUNT);
  assign wr_period = wr_fire & (bus_index == IDX_PERIOD);
  assign wr_control = wr_fire & (bus_index == IDX_CONTROL);
  assign wr_status = wr_fire & (bus_index == IDX_STATUS);
  assign wr_mask = wr_fire & (bus_index == IDX_MASK);
  assign wr_osc = wr_fire & (bus_index == IDX_OSC);
  assign control_next =
    merge16(control_word_q, i_avs_writedata, i_avs_byteenable) & CONTROL_MASK;

  // Control fields
  logic count_enable;
  logic idle_stop;
  logic gate_accumulate_enable;
  logic [1:0] prescale_select;
  logic external_sync_select;
  logic clock_source_select;
  logic lp_osc_enable;

  assign count_enable = control_word_q[CTL_ON];
  assign idle_stop = control_word_q[CTL_IDLE_STOP];
  assign gate_accumulate_enable = control_word_q[CTL_GATE];
  assign prescale_select = control_word_q[CTL_PS_HI:CTL_PS_LO];
  assign external_sync_select = control_word_q[CTL_SYNC];
  assign clock_source_select = control_word_q[CTL_CS];
  assign lp_osc_enable = osc_control_word_q[OSC_LP_EN];

  // Input edges
  logic pin_level;
  logic pin_rise_sync;
  logic pin_fall;
  logic pin_rise_raw;
  logic lp_rise;

  gpt_edge_detect u_pin_edge (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_pin(i_gate_clock_pin),
    .o_level_sync(pin_level),
    .o_rise_sync(pin_rise_sync),
    .o_fall_sync(pin_fall),
    .o_rise_raw(pin_rise_raw)
  );

  gpt_edge_detect u_lp_edge (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_pin(i_lp_osc_clock),
    .o_level_sync(),
    .o_rise_sync(),
    .o_fall_sync(),
    .o_rise_raw(lp_rise)
  );

  // Clock source and run qualification
  logic gated_mode;
  logic async_ext;
  logic src_tick;
  logic run_ok;
  logic pre_tick;
  logic match;
  logic ps_clear;

  assign gated_mode = count_enable & gate_accumulate_enable &
                      ~clock_source_select & ~lp_osc_enable;
  assign async_ext = clock_source_select & ~external_sync_select;

  always_comb begin
    src_tick = 1'b0;
    if (clock_source_select) begin
      if (lp_osc_enable) begin
        src_tick = lp_rise;
      end else if (external_sync_select) begin
        src_tick = pin_rise_sync;
      end else begin
        src_tick = pin_rise_raw;
      end
    end else if (!lp_osc_enable) begin
      // Every clock is one instruction cycle
      src_tick = gate_accumulate_enable ? pin_level : 1'b1;
    end
  end

  // Sleep keeps only the asynchronous external path alive
  assign run_ok = count_enable &
                  ~(i_cpu_idle & idle_stop) &
                  ~(i_cpu_sleep & ~async_ext);

  // Only an enabled prescaler can be cleared
  assign ps_clear = (wr_count & count_enable) |
                    (wr_control & count_enable & ~control_next[CTL_ON]);

  gpt_prescaler u_prescaler (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_enable(count_enable),
    .i_clear(ps_clear),
    .i_select(prescale_select),
    .i_tick(src_tick & run_ok),
    .o_tick(pre_tick)
  );

  assign match = pre_tick & (count_value_q == period_value_q);

  // Count register: of the bus writes only its own changes it; match and pre_tick also change it
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      count_value_q <= COUNT_RESET;
    end else if (wr_count) begin
      count_value_q <= merge16(count_value_q, i_avs_writedata, i_avs_byteenable);
    end else if (match) begin
      count_value_q <= COUNT_RESET;
    end else if (pre_tick) begin
      count_value_q <= count_value_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      period_value_q <= PERIOD_RESET;
    end else if (wr_period) begin
      period_value_q <= merge16(period_value_q, i_avs_writedata, i_avs_byteenable);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      control_word_q <= CONTROL_RESET;
    end else if (wr_control) begin
      control_word_q <= control_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      osc_control_word_q <= OSC_RESET;
    end else if (wr_osc) begin
      osc_control_word_q <=
        merge16(osc_control_word_q, i_avs_writedata, i_avs_byteenable) & OSC_MASK;
    end
  end

  // Sticky events; a new event beats a write-one clear
  logic [ST_W-1:0] event_set;
  logic [ST_W-1:0] status_clear;

  always_comb begin
    event_set = '0;
    event_set[ST_MATCH] = match;
    event_set[ST_GATE] = gated_mode & pin_fall;
    event_set[ST_WAKE] = match & lp_osc_enable;
    status_clear = '0;
    if (wr_status && i_avs_byteenable[0]) begin
      status_clear = i_avs_writedata[ST_W-1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= (status_q & ~status_clear) | event_set;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      mask_q <= STATUS_RESET;
    end else if (wr_mask && i_avs_byteenable[0]) begin
      mask_q <= i_avs_writedata[ST_W-1:0];
    end
  end

  // Wake pulse follows the carry-out by one cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= match & lp_osc_enable;
    end
  end

  assign o_irq = |(status_q & mask_q);
  assign o_wake_event = wake_q;

  // One wait cycle lets read data settle in a flop first
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      readdata_q <= '0;
    end else if (i_avs_read && !ack_q) begin
      case (bus_index)
        IDX_COUNT: readdata_q <= {16'h0000, count_value_q};
        IDX_PERIOD: readdata_q <= {16'h0000, period_value_q};
        IDX_CONTROL: readdata_q <= {16'h0000, control_word_q};
        IDX_STATUS: readdata_q <= {29'h0000000, status_q};
        IDX_MASK: readdata_q <= {29'h0000000, mask_q};
        IDX_OSC: readdata_q <= {16'h0000, osc_control_word_q};
        default: readdata_q <= '0;
      endcase
    end
  end

  assign o_avs_readdata = readdata_q;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  wrap_to_zero_a: assert property (
    match && !wr_count |=> count_value_q == COUNT_RESET
  ) else $error("count did not wrap to zero on match");

  count_step_a: assert property (
    pre_tick && !match && !wr_count |=> count_value_q == $past(count_value_q) + 16'h0001
  ) else $error("count did not step by one");

  idle_freeze_a: assert property (
    i_cpu_idle && idle_stop && !wr_count |=> $stable(count_value_q)
  ) else $error("count moved in idle with idle_stop set");

  sleep_freeze_a: assert property (
    i_cpu_sleep && !async_ext && !wr_count |=> $stable(count_value_q)
  ) else $error("count moved in sleep without async external clock");

  match_flag_a: assert property (
    match |=> status_q[ST_MATCH] ##1 (status_q[ST_MATCH] || $past(status_clear[ST_MATCH]))
  ) else $error("match flag not set or not sticky");

  gate_flag_a: assert property (
    gated_mode && pin_fall |=> status_q[ST_GATE]
  ) else $error("gate falling edge did not set flag");

  control_keeps_count_a: assert property (
    wr_control && !pre_tick && !wr_count |=> $stable(count_value_q)
  ) else $error("control write changed count");

  halted_count_a: assert property (
    !count_enable && !wr_count |=> $stable(count_value_q)
  ) else $error("count moved while disabled");

  lp_block_a: assert property (
    lp_osc_enable && !clock_source_select && !wr_count |=> $stable(count_value_q)
  ) else $error("internal mode ran with lp_osc_enable set");

  gate_low_hold_a: assert property (
    gated_mode && !pin_level && !wr_count |=> $stable(count_value_q)
  ) else $error("gated count moved with gate low");

  div8_spacing_a: assert property (
    pre_tick && prescale_select == 2'h1 && !ps_clear && !wr_control
      |=> !pre_tick [*7]
  ) else $error("divide by eight tick too early");

  bus_answer_a: assert property (
    (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest
  ) else $error("bus answer took more than one wait cycle");

endmodule // gpt_timer

/* File: tb/gpt_far_model.sv */
`timescale 1ns/1ps
module gpt_far_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Burst request from the bench
  input wire logic i_start,
  input wire logic i_to_osc,
  input wire logic [7:0] i_pulses,
  input wire logic [7:0] i_half,
  // Far-side lines
  output logic o_pin,
  output logic o_lp_osc,
  output logic o_busy
);
  logic [7:0] left_q;
  logic [7:0] tm_q;
  logic lvl_q;

  // A stopped source clock rests low between bursts
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      left_q <= 8'h00;
      tm_q <= 8'h00;
      lvl_q <= 1'b0;
    end else if (i_start) begin
      left_q <= i_pulses;
      tm_q <= i_half - 8'h01;
      lvl_q <= 1'b1;
    end else if (left_q != 8'h00) begin
      if (tm_q == 8'h00) begin
        tm_q <= i_half - 8'h01;
        lvl_q <= ~lvl_q;
        if (lvl_q) begin
          left_q <= left_q - 8'h01;
        end
      end else begin
        tm_q <= tm_q - 8'h01;
      end
    end
  end

  assign o_pin = ~i_to_osc & lvl_q;
  assign o_lp_osc = i_to_osc & lvl_q;
  assign o_busy = left_q != 8'h00;
endmodule // gpt_far_model

/* File: tb/gpt_timer_tb.sv */
`timescale 1ns/1ps
module gpt_timer_tb;
  import gpt_pkg::*;
  typedef struct {
    logic [15:0] ctl;
    logic idle;
    logic sleep;
    logic src;
    logic [7:0] k;
    logic [7:0] h;
    int n;
    logic [15:0] exp;
  } gpt_row_type;
  logic i_clock = 1'b0;
  logic i_rst_b;
  logic [11:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic i_cpu_idle;
  logic i_cpu_sleep;
  logic o_irq;
  logic o_wake_event;
  logic pin;
  logic lp_osc;
  logic fm_start;
  logic fm_src;
  logic [7:0] fm_k;
  logic [7:0] fm_h;
  logic fm_busy;
  logic [15:0] wake_n = 16'h0000;
  logic [15:0] rd_dummy;
  int errors = 0;
  int n_checks = 0;
  gpt_row_type rows [13] = '{
    '{16'h8000, 0, 0, 0, 0, 0, 20, 16'h0017},
    '{16'h8010, 0, 0, 0, 0, 0, 605, 16'h004C},
    '{16'h8020, 0, 0, 0, 0, 0, 637, 16'h000A},
    '{16'h8030, 0, 0, 0, 0, 0, 765, 16'h0003},
    '{16'hA000, 1, 0, 0, 0, 0, 20, 16'h0000},
    '{16'h8000, 1, 0, 0, 0, 0, 20, 16'h0017},
    '{16'h8000, 0, 1, 0, 0, 0, 20, 16'h0000},
    '{16'h8006, 0, 0, 0, 5, 3, 8, 16'h0005},
    '{16'h8002, 0, 0, 0, 5, 3, 8, 16'h0005},
    '{16'hA002, 1, 0, 0, 5, 3, 8, 16'h0000},
    '{16'h8002, 0, 1, 0, 5, 3, 8, 16'h0005},
    '{16'h8006, 0, 1, 0, 5, 3, 8, 16'h0000},
    '{16'h8040, 0, 0, 0, 3, 4, 8, 16'h000C}
  };

  gpt_timer i_dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_gate_clock_pin(pin), .i_lp_osc_clock(lp_osc),
    .i_cpu_idle(i_cpu_idle), .i_cpu_sleep(i_cpu_sleep),
    .o_irq(o_irq), .o_wake_event(o_wake_event)
  );
  gpt_far_model i_far (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_start(fm_start), .i_to_osc(fm_src),
    .i_pulses(fm_k), .i_half(fm_h), .o_pin(pin), .o_lp_osc(lp_osc), .o_busy(fm_busy)
  );

  always #2 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (o_wake_event === 1'b1) begin
      wake_n <= wake_n + 16'h0001;
    end
  end

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd,
      input logic [3:0] be, output logic [15:0] rd);
    @(posedge i_clock);
    i_avs_address <= {idx, 2'b00};
    i_avs_read <= ~wr;
    i_avs_write <= wr;
    i_avs_writedata <= {16'h0000, wd};
    i_avs_byteenable <= be;
    do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
    rd = o_avs_readdata[15:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
    logic [15:0] dummy;
    bus(1'b1, idx, wd, 4'hF, dummy);
  endtask
  task automatic rdchk(input string what, input logic [9:0] idx, input logic [15:0] exp);
    logic [15:0] v;
    bus(1'b0, idx, 16'h0000, 4'hF, v);
    chk16(what, exp, v);
  endtask
  task automatic burst(input logic src, input logic [7:0] k, input logic [7:0] h);
    @(posedge i_clock);
    fm_src <= src;
    fm_k <= k;
    fm_h <= h;
    fm_start <= 1'b1;
    @(posedge i_clock);
    fm_start <= 1'b0;
    do @(negedge i_clock); while (fm_busy !== 1'b0);
  endtask
  // Counting window is n + 3 edges for internal sources
  task automatic run_case(input gpt_row_type r);
    wr(IDX_COUNT, 16'h0000);
    i_cpu_idle <= r.idle;
    i_cpu_sleep <= r.sleep;
    wr(IDX_CONTROL, r.ctl);
    if (r.k != 8'h00) burst(r.src, r.k, r.h);
    repeat (r.n) @(posedge i_clock);
    wr(IDX_CONTROL, 16'h0000);
    i_cpu_idle <= 1'b0;
    i_cpu_sleep <= 1'b0;
    rdchk("count_value", IDX_COUNT, r.exp);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #100000;
    errors = errors + 1;
    results();
  end

  initial begin
    i_rst_b <= 1'b0;
    i_avs_address <= 12'h000;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    i_avs_writedata <= 32'h0000_0000;
    i_avs_byteenable <= 4'h0;
    i_cpu_idle <= 1'b0;
    i_cpu_sleep <= 1'b0;
    fm_start <= 1'b0;
    fm_src <= 1'b0;
    fm_k <= 8'h00;
    fm_h <= 8'h01;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    chk1("irq", 1'b0, o_irq);
    rdchk("count_value", IDX_COUNT, COUNT_RESET);
    rdchk("period_value", IDX_PERIOD, PERIOD_RESET);
    rdchk("control_word", IDX_CONTROL, CONTROL_RESET);
    rdchk("status", IDX_STATUS, 16'h0000);
    rdchk("mask", IDX_MASK, 16'h0000);
    rdchk("osc_control_word", IDX_OSC, OSC_RESET);
    wr(IDX_CONTROL, 16'h7FFF);
    rdchk("control_word", IDX_CONTROL, 16'h2076);
    wr(IDX_OSC, 16'hFFFF);
    rdchk("osc_control_word", IDX_OSC, 16'h0002);
    wr(IDX_MASK, 16'hFFFF);
    rdchk("mask", IDX_MASK, 16'h0007);
    bus(1'b1, IDX_PERIOD, 16'h0000, 4'h1, rd_dummy);
    rdchk("period_value", IDX_PERIOD, 16'hFF00);
    wr(10'h1FF, 16'hFFFF);
    rdchk("unmapped", 10'h1FF, 16'h0000);
    wr(IDX_CONTROL, 16'h0000);
    wr(IDX_OSC, 16'h0000);
    wr(IDX_MASK, 16'h0000);
    wr(IDX_PERIOD, 16'hFFFF);
    $display("test registers done");
    foreach (rows[i]) run_case(rows[i]);
    rdchk("status", IDX_STATUS, 16'h0002);
    wr(IDX_STATUS, 16'h0002);
    rdchk("status", IDX_STATUS, 16'h0000);
    $display("test modes done");
    wr(IDX_PERIOD, 16'h0005);
    run_case('{16'h8000, 0, 0, 0, 0, 0, 20, 16'h0005});
    rdchk("period_irq_flag", IDX_STATUS, 16'h0001);
    wr(IDX_MASK, 16'h0001);
    @(negedge i_clock);
    chk1("irq", 1'b1, o_irq);
    wr(IDX_CONTROL, 16'h2000);
    rdchk("count_value", IDX_COUNT, 16'h0005);
    wr(IDX_STATUS, 16'h0001);
    @(negedge i_clock);
    chk1("irq", 1'b0, o_irq);
    $display("test match done");
    wr(IDX_PERIOD, 16'hFFFF);
    wr(IDX_CONTROL, 16'h8030);
    repeat (200) @(posedge i_clock);
    wr(IDX_COUNT, 16'h0000);
    repeat (250) @(posedge i_clock);
    wr(IDX_CONTROL, 16'h0000);
    rdchk("count_value", IDX_COUNT, 16'h0000);
    $display("test prescaler clear done");
    wr(IDX_PERIOD, 16'h0003);
    wr(IDX_OSC, 16'h0002);
    run_case('{16'h8002, 1, 1, 1, 4, 5, 8, 16'h0000});
    chk16("wake events", 16'h0001, wake_n);
    rdchk("status", IDX_STATUS, 16'h0005);
    run_case('{16'h8002, 0, 0, 0, 3, 4, 8, 16'h0000});
    run_case('{16'h8000, 0, 0, 0, 0, 0, 20, 16'h0000});
    $display("test low power oscillator done");
    // Reset in mid-run, with status and mask still holding an active irq
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    chk1("irq", 1'b0, o_irq);
    rdchk("count_value", IDX_COUNT, COUNT_RESET);
    rdchk("period_value", IDX_PERIOD, PERIOD_RESET);
    rdchk("status", IDX_STATUS, 16'h0000);
    rdchk("mask", IDX_MASK, 16'h0000);
    rdchk("osc_control_word", IDX_OSC, OSC_RESET);
    $display("test reset done");
    results();
  end
endmodule // gpt_timer_tb
